/* File: core/gen_ctrl.sv */
// general control low bits: control register, irq1/irq12 latches and decode steering
// assumes an axi4-lite master, synchronous inputs and one clock
//
// Overview of operation
// - with kbd latch enabled the keyboard irq edge is held until a port 60h read, else passes.
// - with mouse latch enabled the mouse irq edge is held until a port 60h read, else passes.
// - with interrupt controller disabled no standard or extended controller space is decoded.
// - with controller enabled and extension disabled only standard space is decoded.
// - with both enabled standard and extended space decode and message interrupts are taken.
// - message interrupts have no separate disable when the extended controller is on.
// - alternate access mode, off at reset, opens reads and writes of otherwise closed registers.
// - the dma gather buffer enable switches the collection buffer for lpc and pc/pci dma.
// - delayed transaction enable makes internal, firmware hub and lpc accesses delayed.
// - without positive only decode unclaimed bus cycles are claimed and sent to lpc.
// - internal registers and known lpc devices are always claimed positively.
// - with positive only decode nothing is claimed subtractively.
`timescale 1ns/1ps
module gen_ctrl
   import gen_ctrl_pkg::*;
#(
   parameter int ADDR_BITS = ADDR_W
) (
   input wire logic clk,
   input wire logic resetn,
   // axi4-lite slave
   input wire logic [ADDR_BITS-1:0] s_awaddr,
   input wire logic s_awvalid,
   output logic s_awready,
   input wire logic [DATA_W-1:0] s_wdata,
   input wire logic [3:0] s_wstrb,
   input wire logic s_wvalid,
   output logic s_wready,
   output logic [1:0] s_bresp,
   output logic s_bvalid,
   input wire logic s_bready,
   input wire logic [ADDR_BITS-1:0] s_araddr,
   input wire logic s_arvalid,
   output logic s_arready,
   output logic [DATA_W-1:0] s_rdata,
   output logic [1:0] s_rresp,
   output logic s_rvalid,
   input wire logic s_rready,
   // legacy interrupts and keyboard port read
   input wire logic kbd_irq_in,
   input wire logic mouse_irq_in,
   input wire logic io_read_strobe,
   input wire logic [15:0] io_read_addr,
   output logic kbd_irq_out,
   output logic mouse_irq_out,
   // primary bus decode
   input wire cycle_t cycle_in,
   input wire logic msg_irq_write,
   output decode_t decode_out,
   output logic msg_irq_take,
   // control levels to the rest of the hub
   output ctrl_t ctrl_out
);

   initial begin
      if (ADDR_BITS < 4 || ADDR_BITS > ADDR_W) begin
         $error("gen_ctrl: ADDR_BITS out of range");
      end
   end

   function automatic logic [ADDR_W-1:0] word_addr(input logic [ADDR_BITS-1:0] a);
      logic [ADDR_W-1:0] w;
      w = ADDR_W'(a);
      w[1:0] = 2'b00;
      return w;
   endfunction : word_addr

   function automatic logic [DATA_W-1:0] apply_strb(input logic [DATA_W-1:0] old,
         input logic [DATA_W-1:0] nw, input logic [3:0] strb);
      logic [DATA_W-1:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            r[i*8 +: 8] = nw[i*8 +: 8];
         end
      end
      return r;
   endfunction : apply_strb

   // register state
   logic [DATA_W-1:0] gen_ctrl_q, gen_ctrl_d;
   logic [DATA_W-1:0] alt_shadow_q, alt_shadow_d;
   logic kbd_latch_q, kbd_latch_d;
   logic mouse_latch_q, mouse_latch_d;
   logic kbd_prev_q, kbd_prev_d;
   logic mouse_prev_q, mouse_prev_d;

   // write channel state
   logic aw_held_q, aw_held_d;
   logic w_held_q, w_held_d;
   logic [ADDR_BITS-1:0] awaddr_q, awaddr_d;
   logic [DATA_W-1:0] wdata_q, wdata_d;
   logic [3:0] wstrb_q, wstrb_d;
   logic bvalid_q, bvalid_d;
   logic [1:0] bresp_q, bresp_d;

   // read channel state
   logic rvalid_q, rvalid_d;
   logic [DATA_W-1:0] rdata_q, rdata_d;
   logic [1:0] rresp_q, rresp_d;

   logic alt_on;
   logic port60_read;
   logic do_write;
   logic [ADDR_W-1:0] waddr;
   logic [ADDR_W-1:0] raddr;

   assign alt_on = gen_ctrl_q[POS_ALT_ACCESS];
   assign port60_read = io_read_strobe && (io_read_addr == KBD_DATA_PORT);

   assign s_awready = !aw_held_q && !bvalid_q;
   assign s_wready = !w_held_q && !bvalid_q;
   assign s_bvalid = bvalid_q;
   assign s_bresp = bresp_q;
   assign s_arready = !rvalid_q;
   assign s_rvalid = rvalid_q;
   assign s_rdata = rdata_q;
   assign s_rresp = rresp_q;

   // write path: address and data taken in either order, response after both
   always_comb begin
      aw_held_d = aw_held_q;
      w_held_d = w_held_q;
      awaddr_d = awaddr_q;
      wdata_d = wdata_q;
      wstrb_d = wstrb_q;
      bvalid_d = bvalid_q;
      bresp_d = bresp_q;
      gen_ctrl_d = gen_ctrl_q;
      alt_shadow_d = alt_shadow_q;
      do_write = 1'b0;
      waddr = word_addr(awaddr_q);
      if (s_awvalid && s_awready) begin
         aw_held_d = 1'b1;
         awaddr_d = s_awaddr;
      end
      if (s_wvalid && s_wready) begin
         w_held_d = 1'b1;
         wdata_d = s_wdata;
         wstrb_d = s_wstrb;
      end
      if (aw_held_q && w_held_q) begin
         do_write = 1'b1;
         aw_held_d = 1'b0;
         w_held_d = 1'b0;
         bvalid_d = 1'b1;
         bresp_d = RESP_OKAY;
         case (waddr)
            GEN_CTRL_OFF: begin
               gen_ctrl_d = apply_strb(gen_ctrl_q, wdata_q, wstrb_q) & GEN_CTRL_MASK;
            end
            ALT_SHADOW_OFF: begin
               if (alt_on) begin
                  alt_shadow_d = apply_strb(alt_shadow_q, wdata_q, wstrb_q);
               end
            end
            STATUS_OFF: begin
               bresp_d = RESP_OKAY;
            end
            default: begin
               bresp_d = RESP_SLVERR;
            end
         endcase
      end
      if (bvalid_q && s_bready) begin
         bvalid_d = 1'b0;
      end
   end

   // read path: one cycle after the address is taken
   always_comb begin
      rvalid_d = rvalid_q;
      rdata_d = rdata_q;
      rresp_d = rresp_q;
      raddr = word_addr(s_araddr);
      if (rvalid_q && s_rready) begin
         rvalid_d = 1'b0;
      end
      if (s_arvalid && s_arready) begin
         rvalid_d = 1'b1;
         rresp_d = RESP_OKAY;
         rdata_d = '0;
         case (raddr)
            GEN_CTRL_OFF: begin
               rdata_d = gen_ctrl_q;
            end
            STATUS_OFF: begin
               rdata_d = {30'h0000_0000, mouse_latch_q, kbd_latch_q};
            end
            ALT_SHADOW_OFF: begin
               if (alt_on) begin
                  rdata_d = alt_shadow_q;
               end
            end
            default: begin
               rresp_d = RESP_SLVERR;
            end
         endcase
      end
   end

   // irq latches: set wins over the port 60h clear
   always_comb begin
      kbd_prev_d = kbd_irq_in;
      mouse_prev_d = mouse_irq_in;
      kbd_latch_d = kbd_latch_q;
      mouse_latch_d = mouse_latch_q;
      if (!gen_ctrl_q[POS_KBD_LATCH]) begin
         kbd_latch_d = 1'b0;
      end else if (kbd_irq_in && !kbd_prev_q) begin
         kbd_latch_d = 1'b1;
      end else if (port60_read) begin
         kbd_latch_d = 1'b0;
      end
      if (!gen_ctrl_q[POS_MOUSE_LATCH]) begin
         mouse_latch_d = 1'b0;
      end else if (mouse_irq_in && !mouse_prev_q) begin
         mouse_latch_d = 1'b1;
      end else if (port60_read) begin
         mouse_latch_d = 1'b0;
      end
   end

   assign kbd_irq_out = gen_ctrl_q[POS_KBD_LATCH] ? kbd_latch_q : kbd_irq_in;
   assign mouse_irq_out = gen_ctrl_q[POS_MOUSE_LATCH] ? mouse_latch_q : mouse_irq_in;

   // decode steering
   always_comb begin
      logic intc_std;
      logic intc_ext;
      logic pos_hit;
      intc_std = 1'b0;
      intc_ext = 1'b0;
      pos_hit = 1'b0;
      intc_std = gen_ctrl_q[POS_INTC_EN];
      intc_ext = gen_ctrl_q[POS_INTC_EN] && gen_ctrl_q[POS_INTC_EXT];
      decode_out.decode_intc_std = cycle_in.valid && cycle_in.hits_intc_std && intc_std;
      decode_out.decode_intc_ext = cycle_in.valid && cycle_in.hits_intc_ext && intc_ext;
      decode_out.accept_msg_irq = intc_ext;
      pos_hit = cycle_in.hits_internal || cycle_in.hits_known_lpc
         || (cycle_in.hits_intc_std && intc_std) || (cycle_in.hits_intc_ext && intc_ext);
      decode_out.claim_positive = cycle_in.valid && pos_hit;
      decode_out.claim_subtractive = cycle_in.valid && !pos_hit
         && !gen_ctrl_q[POS_POSITIVE_ONLY];
      decode_out.forward_lpc = (cycle_in.valid && cycle_in.hits_known_lpc)
         || decode_out.claim_subtractive;
   end

   assign msg_irq_take = msg_irq_write && gen_ctrl_q[POS_INTC_EN] && gen_ctrl_q[POS_INTC_EXT];

   always_comb begin
      ctrl_out.kbd_irq_latch_en = gen_ctrl_q[POS_KBD_LATCH];
      ctrl_out.mouse_irq_latch_en = gen_ctrl_q[POS_MOUSE_LATCH];
      ctrl_out.intc_enable = gen_ctrl_q[POS_INTC_EN];
      ctrl_out.intc_ext_enable = gen_ctrl_q[POS_INTC_EXT];
      ctrl_out.alt_access_enable = gen_ctrl_q[POS_ALT_ACCESS];
      ctrl_out.dma_gather_buffer_en = gen_ctrl_q[POS_DMA_GATHER];
      ctrl_out.delayed_txn_enable = gen_ctrl_q[POS_DELAYED_TXN];
      ctrl_out.positive_only_decode = gen_ctrl_q[POS_POSITIVE_ONLY];
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         gen_ctrl_q <= GEN_CTRL_RESET;
         alt_shadow_q <= ALT_SHADOW_RESET;
         kbd_latch_q <= 1'b0;
         mouse_latch_q <= 1'b0;
         kbd_prev_q <= 1'b0;
         mouse_prev_q <= 1'b0;
         aw_held_q <= 1'b0;
         w_held_q <= 1'b0;
         awaddr_q <= '0;
         wdata_q <= '0;
         wstrb_q <= 4'h0;
         bvalid_q <= 1'b0;
         bresp_q <= RESP_OKAY;
         rvalid_q <= 1'b0;
         rdata_q <= '0;
         rresp_q <= RESP_OKAY;
      end else begin
         gen_ctrl_q <= gen_ctrl_d;
         alt_shadow_q <= alt_shadow_d;
         kbd_latch_q <= kbd_latch_d;
         mouse_latch_q <= mouse_latch_d;
         kbd_prev_q <= kbd_prev_d;
         mouse_prev_q <= mouse_prev_d;
         aw_held_q <= aw_held_d;
         w_held_q <= w_held_d;
         awaddr_q <= awaddr_d;
         wdata_q <= wdata_d;
         wstrb_q <= wstrb_d;
         bvalid_q <= bvalid_d;
         bresp_q <= bresp_d;
         rvalid_q <= rvalid_d;
         rdata_q <= rdata_d;
         rresp_q <= rresp_d;
      end
   end

endmodule : gen_ctrl

/* File: core/gen_ctrl_pkg.sv */
// package for the general control low bits block: offsets, field positions, carriers
// assumes a 32-bit axi4-lite register bus and one 100 MHz clock
package gen_ctrl_pkg;

   localparam int DATA_W = 32;
   localparam int ADDR_W = 8;

   // register byte addresses
   localparam logic [ADDR_W-1:0] GEN_CTRL_OFF = 8'h00;
   localparam logic [ADDR_W-1:0] STATUS_OFF = 8'h04;
   localparam logic [ADDR_W-1:0] ALT_SHADOW_OFF = 8'h08;

   // general control field positions
   localparam int POS_POSITIVE_ONLY = 0;
   localparam int POS_DELAYED_TXN = 1;
   localparam int POS_DMA_GATHER = 2;
   localparam int POS_ALT_ACCESS = 6;
   localparam int POS_INTC_EXT = 7;
   localparam int POS_INTC_EN = 8;
   localparam int POS_MOUSE_LATCH = 11;
   localparam int POS_KBD_LATCH = 12;

   // writable bits of general control; everything else reads zero
   localparam logic [DATA_W-1:0] GEN_CTRL_MASK = 32'h0000_19C7;
   localparam logic [DATA_W-1:0] GEN_CTRL_RESET = 32'h0000_0000;
   localparam logic [DATA_W-1:0] ALT_SHADOW_RESET = 32'h0000_0000;

   // keyboard data port
   localparam logic [15:0] KBD_DATA_PORT = 16'h0060;

   // axi response codes
   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;

   typedef struct packed {
      logic kbd_irq_latch_en;
      logic mouse_irq_latch_en;
      logic intc_enable;
      logic intc_ext_enable;
      logic alt_access_enable;
      logic dma_gather_buffer_en;
      logic delayed_txn_enable;
      logic positive_only_decode;
   } ctrl_t;

   // primary bus cycle presented for decode
   typedef struct packed {
      logic valid;
      logic hits_internal;
      logic hits_known_lpc;
      logic hits_intc_std;
      logic hits_intc_ext;
   } cycle_t;

   typedef struct packed {
      logic claim_positive;
      logic claim_subtractive;
      logic forward_lpc;
      logic decode_intc_std;
      logic decode_intc_ext;
      logic accept_msg_irq;
   } decode_t;

endpackage : gen_ctrl_pkg

/* File: testbench/gen_ctrl_sva.sv */
// checker for general control: decode steering, message take, keyboard latch, read hold
// assumes binding to gen_ctrl with one clock and synchronous active-low reset
`timescale 1ns/1ps
module gen_ctrl_sva
   import gen_ctrl_pkg::*;
(
   input wire logic clk,
   input wire logic resetn,
   input wire logic kbd_irq_in,
   input wire logic io_read_strobe,
   input wire logic [15:0] io_read_addr,
   input wire logic kbd_irq_out,
   input wire cycle_t cycle_in,
   input wire logic msg_irq_write,
   input wire decode_t decode_out,
   input wire logic msg_irq_take,
   input wire ctrl_t ctrl_out,
   input wire logic s_rvalid,
   input wire logic s_rready,
   input wire logic [DATA_W-1:0] s_rdata
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);
   logic clr;
   assign clr = io_read_strobe && io_read_addr == KBD_DATA_PORT;
   sequence kbd_edge;
      ctrl_out.kbd_irq_latch_en && $rose(kbd_irq_in);
   endsequence
   sequence kbd_held;
      ctrl_out.kbd_irq_latch_en && kbd_irq_out && !clr;
   endsequence
   a_kbd_capture: assert property (kbd_edge ##1 ctrl_out.kbd_irq_latch_en |-> kbd_irq_out)
      else $error("keyboard edge not latched");
   a_kbd_hold: assert property (kbd_held ##1 ctrl_out.kbd_irq_latch_en |-> kbd_irq_out)
      else $error("keyboard latch dropped without port read");
   a_kbd_bypass: assert property (!ctrl_out.kbd_irq_latch_en |-> kbd_irq_out == kbd_irq_in)
      else $error("keyboard irq not passed through");
   a_intc_off: assert property (!ctrl_out.intc_enable |->
      !decode_out.decode_intc_std && !decode_out.decode_intc_ext)
      else $error("controller space decoded while disabled");
   a_ext_off: assert property (!ctrl_out.intc_ext_enable |-> !decode_out.decode_intc_ext)
      else $error("extended space decoded while extension off");
   a_msg_take: assert property (msg_irq_take ==
      (msg_irq_write && ctrl_out.intc_enable && ctrl_out.intc_ext_enable))
      else $error("message interrupt take wrong");
   a_known_pos: assert property (cycle_in.valid && (cycle_in.hits_internal ||
      cycle_in.hits_known_lpc) |-> decode_out.claim_positive && !decode_out.claim_subtractive)
      else $error("known target not positively claimed");
   a_pos_only: assert property (ctrl_out.positive_only_decode |-> !decode_out.claim_subtractive)
      else $error("subtractive claim in positive mode");
   a_read_hold: assert property (s_rvalid && !s_rready |=> s_rvalid && $stable(s_rdata))
      else $error("read answer not held");
endmodule : gen_ctrl_sva

bind gen_ctrl gen_ctrl_sva gen_ctrl_sva_inst (.clk, .resetn, .kbd_irq_in, .io_read_strobe,
   .io_read_addr, .kbd_irq_out, .cycle_in, .msg_irq_write, .decode_out, .msg_irq_take,
   .ctrl_out, .s_rvalid, .s_rready, .s_rdata);

/* File: testbench/gen_ctrl_tb.sv */
// self-checking bench for gen_ctrl: register bus, latches and decode steering
// assumes the design as instantiated here with default address width
`timescale 1ns/1ps
module gen_ctrl_tb;
   import gen_ctrl_pkg::*;
   logic clk = 0, resetn = 0;
   logic [7:0] awaddr = 0, araddr = 0;
   logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic [31:0] wdata = 0, rdata, rd;
   logic [3:0] wstrb = 4'hF;
   logic [1:0] bresp, rresp, resp;
   logic bvalid, rvalid, awready, wready, arready, kin = 0, min = 0, kout, mout;
   logic ios = 0, msgw = 0, take;
   logic [15:0] ioa = 0;
   cycle_t cyc = '0;
   decode_t dec;
   ctrl_t ctl;
   int bad_count = 0, n_tests = 0;
   gen_ctrl gen_ctrl_inst (.clk, .resetn, .s_awaddr(awaddr), .s_awvalid(awvalid),
      .s_awready(awready), .s_wdata(wdata), .s_wstrb(wstrb), .s_wvalid(wvalid),
      .s_wready(wready), .s_bresp(bresp), .s_bvalid(bvalid), .s_bready(bready),
      .s_araddr(araddr), .s_arvalid(arvalid), .s_arready(arready), .s_rdata(rdata),
      .s_rresp(rresp), .s_rvalid(rvalid), .s_rready(rready), .kbd_irq_in(kin),
      .mouse_irq_in(min), .io_read_strobe(ios), .io_read_addr(ioa), .kbd_irq_out(kout),
      .mouse_irq_out(mout), .cycle_in(cyc), .msg_irq_write(msgw), .decode_out(dec),
      .msg_irq_take(take), .ctrl_out(ctl));
   initial forever #5 clk = ~clk;
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         bad_count++;
         $display("BAD %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic ad, wd, at, wt;
      ad = 0;
      wd = 0;
      @(posedge clk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1;
      wvalid <= 1;
      while (!(ad && wd)) begin
         @(negedge clk);
         at = awready && awvalid;
         wt = wready && wvalid;
         @(posedge clk);
         if (at) begin awvalid <= 0; ad = 1; end
         if (wt) begin wvalid <= 0; wd = 1; end
      end
      bready <= 1;
      do @(negedge clk); while (bvalid !== 1'b1);
      resp = bresp;
      @(posedge clk);
      bready <= 0;
   endtask : wr
   task automatic rdr(input logic [7:0] a);
      @(posedge clk);
      araddr <= a;
      arvalid <= 1;
      do @(negedge clk); while (arready !== 1'b1);
      @(posedge clk);
      arvalid <= 0;
      rready <= 1;
      do @(negedge clk); while (rvalid !== 1'b1);
      rd = rdata;
      resp = rresp;
      @(posedge clk);
      rready <= 0;
   endtask : rdr
   task automatic t_regs();
      rdr(GEN_CTRL_OFF);
      chk("ctrl reset", rd, 32'h0000_0000);
      chk("ctrl_out reset", 32'(ctl), 32'h0000_0000);
      wr(GEN_CTRL_OFF, 32'hFFFF_FFFF);
      rdr(GEN_CTRL_OFF);
      chk("ctrl mask", rd, 32'h0000_19C7);
      chk("ctrl_out all", 32'(ctl), 32'h0000_00FF);
      wr(GEN_CTRL_OFF, 32'h0000_0004);
      chk("dma only", 32'(ctl), 32'h0000_0004);
      rdr(8'h40);
      chk("unmapped rd", 32'(resp), 32'(RESP_SLVERR));
   endtask : t_regs
   task automatic t_alt();
      wr(GEN_CTRL_OFF, 32'h0000_0000);
      wr(ALT_SHADOW_OFF, 32'h0000_00A5);
      rdr(ALT_SHADOW_OFF);
      chk("alt closed", rd, 32'h0000_0000);
      wr(GEN_CTRL_OFF, 32'h0000_0040);
      wr(ALT_SHADOW_OFF, 32'h0000_00A5);
      rdr(ALT_SHADOW_OFF);
      chk("alt open", rd, 32'h0000_00A5);
   endtask : t_alt
   task automatic t_intc();
      for (int i = 0; i < 4; i++) begin
         wr(GEN_CTRL_OFF, {23'h0, i[1], i[0], 7'h00});
         @(posedge clk);
         cyc <= '{valid: 1, hits_intc_std: 1, hits_intc_ext: 1, default: 0};
         msgw <= 1;
         @(negedge clk);
         chk("intc std", dec.decode_intc_std, i[1]);
         chk("intc ext", dec.decode_intc_ext, i[1] & i[0]);
         chk("msg take", take, i[1] & i[0]);
         chk("accept msg", dec.accept_msg_irq, i[1] & i[0]);
      end
      msgw <= 0;
   endtask : t_intc
   task automatic t_decode();
      for (int p = 0; p < 2; p++) begin
         wr(GEN_CTRL_OFF, 32'(p));
         @(posedge clk);
         cyc <= '{valid: 1, default: 0};
         @(negedge clk);
         chk("subtractive", dec.claim_subtractive, !p);
         chk("forward lpc", dec.forward_lpc, !p);
         @(posedge clk);
         cyc <= '{valid: 1, hits_internal: 1, default: 0};
         @(negedge clk);
         chk("internal pos", {dec.claim_positive, dec.claim_subtractive}, 2'b10);
      end
   endtask : t_decode
   task automatic t_latch();
      wr(GEN_CTRL_OFF, 32'h0000_1800);
      @(posedge clk) begin kin <= 1; min <= 1; end
      @(posedge clk) begin kin <= 0; min <= 0; ioa <= 16'h0064; ios <= 1; end
      @(posedge clk) ios <= 0;
      repeat (2) @(posedge clk);
      @(negedge clk);
      chk("latched", {kout, mout}, 2'b11);
      rdr(STATUS_OFF);
      chk("latch status", rd, 32'h0000_0003);
      @(posedge clk) begin ioa <= KBD_DATA_PORT; ios <= 1; end
      @(posedge clk) ios <= 0;
      @(negedge clk);
      chk("cleared", {kout, mout}, 2'b00);
      wr(GEN_CTRL_OFF, 32'h0000_0000);
      @(posedge clk) begin kin <= 1; min <= 1; end
      @(negedge clk);
      chk("bypass", {kout, mout}, 2'b11);
      @(posedge clk) begin kin <= 0; min <= 0; end
   endtask : t_latch
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : tally_and_finish
   initial begin
      #100000;
      bad_count++;
      tally_and_finish();
   end
   initial begin
      repeat (16) @(posedge clk);
      resetn <= 1;
      t_regs();
      t_alt();
      t_intc();
      t_decode();
      t_latch();
      tally_and_finish();
   end
endmodule : gen_ctrl_tb
